// *** core/pfc_pin_ctrl.sv ***
// Pin-seven function control: one general-purpose pin with its control word,
// debounce, edge interrupt and routing to and from internal functions.
// Assumes internal sources and request sinks run on hclk; only pin_in is
// asynchronous. The pad resolves the wire from pin_out and pin_oe_n.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps

module pfc_pin_ctrl
  import pfc_pkg::*;
#(
  parameter int LONG_DB_CYCLES = LONG_DEBOUNCE_CYC,
  parameter int NORMAL_DB_CYCLES = NORMAL_DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pad
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  output logic pull_up_en,
  output logic pull_down_en,
  output logic supply_domain_select,
  // Internal functions
  input wire pfc_src_t src,
  output pfc_req_t req,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pfc_ctrl_t ctrl;
    logic int_status;
    logic int_mask;
    logic out_level;
    logic sync1;
    logic sync2;
    logic db_level;
    logic [DB_CNT_W-1:0] db_cnt;
    logic prev_active;
    logic in_level;
    pfc_req_t req;
    logic pin_out;
    logic pin_oe_n;
    logic pull_up;
    logic pull_down;
    logic supply;
    logic irq;
    logic ap_valid;
    logic ap_write;
    pfc_sel_t ap_sel;
    logic [31:0] hrdata;
  } pfc_state_t;

  pfc_state_t st;
  pfc_state_t next_st;

  localparam pfc_state_t STATE_RESET = '{
    ctrl: CTRL_RESET,
    int_status: INT_STATUS_RESET,
    int_mask: INT_MASK_RESET,
    out_level: OUT_LEVEL_RESET,
    req: '0,
    pin_oe_n: 1'b1,
    pull_down: 1'b1,
    ap_sel: SEL_NONE,
    default: '0
  };

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic pfc_sel_t decode(input logic [31:0] addr);
    pfc_sel_t s;
    s = SEL_NONE;
    if (addr == CTRL_ADDR) s = SEL_CTRL;
    else if (addr == INT_STATUS_ADDR) s = SEL_STAT;
    else if (addr == INT_MASK_ADDR) s = SEL_MASK;
    else if (addr == OUT_LEVEL_ADDR) s = SEL_OUT;
    else if (addr == IN_LEVEL_ADDR) s = SEL_IN;
    return s;
  endfunction

  function automatic logic [31:0] read_word(input pfc_state_t s, input pfc_sel_t sel);
    logic [31:0] w;
    w = '0;
    unique case (sel)
      SEL_CTRL: w = {16'h0000, s.ctrl};
      SEL_STAT: w = {31'h0000_0000, s.int_status};
      SEL_MASK: w = {31'h0000_0000, s.int_mask};
      SEL_OUT: w = {31'h0000_0000, s.out_level};
      SEL_IN: w = {31'h0000_0000, s.in_level};
      SEL_NONE: w = '0;
    endcase
    return w;
  endfunction

  // Long debounce for codes 0, 4, 14 and 15, normal for the rest
  function automatic logic [DB_CNT_W-1:0] db_limit(input logic [3:0] fn);
    logic [DB_CNT_W-1:0] lim;
    lim = DB_CNT_W'(NORMAL_DB_CYCLES);
    if (fn == FN_IN_GP_LONG || fn == FN_IN_SLEEP_WAKE_LONG
        || fn == FN_IN_HW_CTL1_LONG || fn == FN_IN_HW_CTL2_LONG) begin
      lim = DB_CNT_W'(LONG_DB_CYCLES);
    end
    return lim;
  endfunction

  function automatic pfc_req_t route_in(input logic [3:0] fn, input logic a);
    pfc_req_t r;
    r = '0;
    unique case (fn)
      FN_IN_PWR_ONOFF: r.power_onoff = a;
      FN_IN_SLEEP_WAKE, FN_IN_SLEEP_WAKE_LONG: r.sleep_wake = a;
      FN_IN_SLEEP: r.sleep = a;
      FN_IN_PWR_ON: r.power_on = a;
      FN_IN_WATCHDOG: r.watchdog_reset = a;
      FN_IN_VSCALE1: r.voltage_scaling1 = a;
      FN_IN_VSCALE2: r.voltage_scaling2 = a;
      FN_IN_HW_EN1: r.hw_enable1 = a;
      FN_IN_HW_EN2: r.hw_enable2 = a;
      FN_IN_HW_CTL1, FN_IN_HW_CTL1_LONG: r.hw_control1 = a;
      FN_IN_HW_CTL2, FN_IN_HW_CTL2_LONG: r.hw_control2 = a;
      default: r = '0;
    endcase
    return r;
  endfunction

  // Logical (pre-polarity) level for each output function
  function automatic logic route_out(input logic [3:0] fn, input logic lvl,
                                     input pfc_src_t s);
    logic v;
    v = 1'b0;
    unique case (fn)
      FN_OUT_GP: v = lvl;
      FN_OUT_OSC32K: v = s.osc_32k;
      FN_OUT_ON_STATE: v = s.on_state;
      FN_OUT_SLEEP_STATE: v = s.sleep_state;
      FN_OUT_STATE_CHANGE: v = s.state_change;
      FN_OUT_VSCALE1_DONE: v = s.vscale1_done;
      FN_OUT_VSCALE2_DONE: v = s.vscale2_done;
      FN_OUT_EXT_EN1: v = s.ext_power_en1;
      FN_OUT_EXT_EN2: v = s.ext_power_en2;
      FN_OUT_SYS_GOOD: v = s.system_supply_good;
      FN_OUT_CONV_GOOD: v = s.converter_power_good;
      FN_OUT_CLK2M: v = s.ext_power_clk_2m;
      FN_OUT_AUX_RESET: v = s.aux_reset;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic in_mode;
  logic out_mode;
  logic lvl;
  logic active;
  logic edge_seen;
  logic drive;
  logic [DB_CNT_W-1:0] lim;

  always_comb begin
    next_st = st;
    in_mode = st.ctrl.pin_enable && st.ctrl.pin_direction;
    out_mode = st.ctrl.pin_enable && !st.ctrl.pin_direction;

    // Register writes in the data phase
    if (st.ap_valid && st.ap_write) begin
      unique case (st.ap_sel)
        SEL_CTRL: next_st.ctrl = hwdata[15:0] & CTRL_WMASK;
        SEL_STAT: next_st.int_status = st.int_status & ~hwdata[0];
        SEL_MASK: next_st.int_mask = hwdata[0];
        SEL_OUT: next_st.out_level = hwdata[0];
        SEL_IN, SEL_NONE: next_st.ctrl = st.ctrl;
      endcase
    end

    // Synchroniser, then debounce on the synchronised level
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;
    lim = db_limit(st.ctrl.pin_function);
    if (st.sync2 == st.db_level) begin
      next_st.db_cnt = '0;
    end else if (st.db_cnt >= lim - 1'b1) begin
      next_st.db_level = st.sync2;
      next_st.db_cnt = '0;
    end else begin
      next_st.db_cnt = st.db_cnt + 1'b1;
    end

    // Code 1 bypasses the debouncer, all other input codes use it
    lvl = (st.ctrl.pin_function == FN_IN_GP_FAST) ? st.sync2 : st.db_level;
    active = ~(lvl ^ st.ctrl.pin_polarity);
    next_st.prev_active = active;
    // A polarity change flips the active level and may raise one edge event
    edge_seen = st.ctrl.edge_mode ? (active != st.prev_active)
                                  : (active && !st.prev_active);
    // Set wins over a clear written in the same cycle
    if (in_mode && edge_seen) next_st.int_status = 1'b1;

    next_st.in_level = in_mode && active;
    next_st.req = route_in(st.ctrl.pin_function, in_mode && active);

    // Output drive; reserved codes give the inactive level
    drive = ~(route_out(st.ctrl.pin_function, st.out_level, src)
              ^ st.ctrl.pin_polarity);
    if (!out_mode) begin
      next_st.pin_oe_n = 1'b1;
      next_st.pin_out = 1'b0;
    end else if (st.ctrl.open_drain_select) begin
      next_st.pin_oe_n = drive;
      next_st.pin_out = 1'b0;
    end else begin
      next_st.pin_oe_n = 1'b0;
      next_st.pin_out = drive;
    end

    next_st.pull_up = (st.ctrl.pull_select == PULL_UP);
    next_st.pull_down = (st.ctrl.pull_select == PULL_DOWN);
    next_st.supply = st.ctrl.supply_domain_select;
    next_st.irq = next_st.int_status && next_st.int_mask;

    // Address phase; read data comes from the updated copy so a read
    // straight after a write sees the new value
    next_st.ap_valid = hsel && htrans[1] && hready;
    next_st.ap_write = hwrite;
    next_st.ap_sel = decode(haddr);
    if (hsel && htrans[1] && hready && !hwrite) begin
      next_st.hrdata = read_word(next_st, decode(haddr));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  assign pin_out = st.pin_out;
  assign pin_oe_n = st.pin_oe_n;
  assign pull_up_en = st.pull_up;
  assign pull_down_en = st.pull_down;
  assign supply_domain_select = st.supply;
  assign req = st.req;
  assign irq = st.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [DB_CNT_W-1:0] chk_lim;
  assign chk_lim = db_limit(st.ctrl.pin_function);

  property p_dir_input;
    st.ctrl.pin_direction |=> pin_oe_n && !pin_out;
  endproperty
  a_dir_input: assert property (p_dir_input)
    else $error("input direction still drives the pin");

  property p_pull;
    st.ctrl.pull_select == PULL_DOWN |=> pull_down_en && !pull_up_en;
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull-down code does not give pull-down only");

  property p_single_edge;
    in_mode && !st.ctrl.edge_mode && !active && st.prev_active && !st.int_status
      && !(st.ap_valid && st.ap_write) |=> !st.int_status;
  endproperty
  a_single_edge: assert property (p_single_edge)
    else $error("inactive-going edge raised status in single edge mode");

  property p_both_edges;
    in_mode && st.ctrl.edge_mode && (active != st.prev_active) |=> st.int_status;
  endproperty
  a_both_edges: assert property (p_both_edges)
    else $error("edge missed in both-edge mode");

  property p_supply;
    ##1 supply_domain_select == $past(st.ctrl.supply_domain_select);
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply select does not follow control word");

  property p_gp_out;
    out_mode && !st.ctrl.open_drain_select && st.ctrl.pin_function == FN_OUT_GP
      |=> !pin_oe_n && pin_out == ($past(st.out_level) ~^ $past(st.ctrl.pin_polarity));
  endproperty
  a_gp_out: assert property (p_gp_out)
    else $error("output level or polarity wrong");

  property p_open_drain;
    out_mode && st.ctrl.open_drain_select |=> !pin_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain drove high");

  property p_disabled;
    !st.ctrl.pin_enable |=> pin_oe_n;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled pin is driven");

  property p_fast_input;
    in_mode && st.ctrl.pin_function == FN_IN_GP_FAST
      |=> st.in_level == ($past(st.sync2) ~^ $past(st.ctrl.pin_polarity));
  endproperty
  a_fast_input: assert property (p_fast_input)
    else $error("undebounced input level wrong");

  property p_sleep_req;
    in_mode && st.ctrl.pin_function == FN_IN_SLEEP |=> req.sleep == $past(active);
  endproperty
  a_sleep_req: assert property (p_sleep_req)
    else $error("sleep request not routed");

  property p_reserved_out;
    out_mode && !st.ctrl.open_drain_select && st.ctrl.pin_function == 4'h5
      |=> pin_out == !$past(st.ctrl.pin_polarity);
  endproperty
  a_reserved_out: assert property (p_reserved_out)
    else $error("reserved output code not inactive");

  property p_debounce;
    $changed(st.db_level) |-> $past(st.db_cnt) >= $past(chk_lim) - 1'b1;
  endproperty
  a_debounce: assert property (p_debounce)
    else $error("debounced level changed early");

  property p_irq;
    ##1 irq == ($past(next_st.int_status) && $past(next_st.int_mask));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output mismatch");

  c_out_mode: cover property (out_mode && !pin_oe_n);
  c_edge_irq: cover property (st.int_status && st.int_mask ##1 irq);
  c_debounced: cover property ($changed(st.db_level));
  c_open_drain: cover property (out_mode && st.ctrl.open_drain_select && !pin_oe_n);

endmodule

// *** core/pfc_pkg.sv ***
// Package for the pin-seven function control block: register map, field layout,
// function codes, debounce timing and the carrier structs.
// Assumes a single 10 MHz clock and an AHB-Lite register bus.
package pfc_pkg;

  // ----------------------------------------------------------------
  // Clock and debounce timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int LONG_DEBOUNCE_US = 30000;
  localparam int NORMAL_DEBOUNCE_US = 100;
  // Least times, so rounded up to whole cycles
  localparam int LONG_DEBOUNCE_CYC =
    (LONG_DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NORMAL_DEBOUNCE_CYC =
    (NORMAL_DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DB_CNT_W = 20;

  // ----------------------------------------------------------------
  // Register map (control word index is not word aligned, so byte = 4 x index)
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_INDEX = 32'h0000_403E;
  localparam logic [31:0] CTRL_ADDR = {CTRL_INDEX[29:0], 2'b00};
  localparam logic [31:0] INT_STATUS_ADDR = 32'h0001_0400;
  localparam logic [31:0] INT_MASK_ADDR = 32'h0001_0404;
  localparam logic [31:0] OUT_LEVEL_ADDR = 32'h0001_0408;
  localparam logic [31:0] IN_LEVEL_ADDR = 32'h0001_040C;

  localparam logic [15:0] CTRL_RESET = 16'hA400;
  // Bits 8 and 6:4 are reserved and read as zero
  localparam logic [15:0] CTRL_WMASK = 16'hFE8F;
  localparam logic INT_STATUS_RESET = 1'h0;
  localparam logic INT_MASK_RESET = 1'h0;
  localparam logic OUT_LEVEL_RESET = 1'h0;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;

  localparam logic [3:0] FN_IN_GP_LONG = 4'h0;
  localparam logic [3:0] FN_IN_GP_FAST = 4'h1;
  localparam logic [3:0] FN_IN_PWR_ONOFF = 4'h2;
  localparam logic [3:0] FN_IN_SLEEP_WAKE = 4'h3;
  localparam logic [3:0] FN_IN_SLEEP_WAKE_LONG = 4'h4;
  localparam logic [3:0] FN_IN_SLEEP = 4'h5;
  localparam logic [3:0] FN_IN_PWR_ON = 4'h6;
  localparam logic [3:0] FN_IN_WATCHDOG = 4'h7;
  localparam logic [3:0] FN_IN_VSCALE1 = 4'h8;
  localparam logic [3:0] FN_IN_VSCALE2 = 4'h9;
  localparam logic [3:0] FN_IN_HW_EN1 = 4'hA;
  localparam logic [3:0] FN_IN_HW_EN2 = 4'hB;
  localparam logic [3:0] FN_IN_HW_CTL1 = 4'hC;
  localparam logic [3:0] FN_IN_HW_CTL2 = 4'hD;
  localparam logic [3:0] FN_IN_HW_CTL1_LONG = 4'hE;
  localparam logic [3:0] FN_IN_HW_CTL2_LONG = 4'hF;

  localparam logic [3:0] FN_OUT_GP = 4'h0;
  localparam logic [3:0] FN_OUT_OSC32K = 4'h1;
  localparam logic [3:0] FN_OUT_ON_STATE = 4'h2;
  localparam logic [3:0] FN_OUT_SLEEP_STATE = 4'h3;
  localparam logic [3:0] FN_OUT_STATE_CHANGE = 4'h4;
  localparam logic [3:0] FN_OUT_VSCALE1_DONE = 4'h8;
  localparam logic [3:0] FN_OUT_VSCALE2_DONE = 4'h9;
  localparam logic [3:0] FN_OUT_EXT_EN1 = 4'hA;
  localparam logic [3:0] FN_OUT_EXT_EN2 = 4'hB;
  localparam logic [3:0] FN_OUT_SYS_GOOD = 4'hC;
  localparam logic [3:0] FN_OUT_CONV_GOOD = 4'hD;
  localparam logic [3:0] FN_OUT_CLK2M = 4'hE;
  localparam logic [3:0] FN_OUT_AUX_RESET = 4'hF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pin_direction;
    logic [1:0] pull_select;
    logic edge_mode;
    logic supply_domain_select;
    logic pin_polarity;
    logic open_drain_select;
    logic rsv8;
    logic pin_enable;
    logic [2:0] rsv6_4;
    logic [3:0] pin_function;
  } pfc_ctrl_t;

  // Internal status sources the pin may drive out
  typedef struct packed {
    logic osc_32k;
    logic on_state;
    logic sleep_state;
    logic state_change;
    logic vscale1_done;
    logic vscale2_done;
    logic ext_power_en1;
    logic ext_power_en2;
    logic system_supply_good;
    logic converter_power_good;
    logic ext_power_clk_2m;
    logic aux_reset;
  } pfc_src_t;

  // Requests the pin may feed as an input
  typedef struct packed {
    logic power_onoff;
    logic sleep_wake;
    logic sleep;
    logic power_on;
    logic watchdog_reset;
    logic voltage_scaling1;
    logic voltage_scaling2;
    logic hw_enable1;
    logic hw_enable2;
    logic hw_control1;
    logic hw_control2;
  } pfc_req_t;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_CTRL, SEL_STAT, SEL_MASK, SEL_OUT, SEL_IN
  } pfc_sel_t;

endpackage

// *** verification/pfc_pad_model.sv ***
// Board-side model of the pin: resolves the wire from the block's drive,
// the pulls and a board driver.
// Assumes hclk is the block clock; an undriven, unpulled wire toggles.
`timescale 1ns/100ps

module pfc_pad_model (
  // Clock
  input wire logic hclk,
  // Block side
  input wire logic pin_out,
  input wire logic pin_oe_n,
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  // Board driver
  input wire logic ext_en,
  input wire logic ext_level,
  // Resolved wire
  output logic wire_level
);
  logic float_level = 1'b0;

  // A floating wire must never look like a clean level
  always @(posedge hclk) begin
    float_level <= ~float_level;
  end

  always_comb begin
    if (!pin_oe_n) begin
      wire_level = pin_out;
    end else if (ext_en) begin
      wire_level = ext_level;
    end else if (pull_up_en) begin
      wire_level = 1'b1;
    end else if (pull_down_en) begin
      wire_level = 1'b0;
    end else begin
      wire_level = float_level;
    end
  end
endmodule

// *** verification/tb_pfc_pin_ctrl.sv ***
// Testbench for the pin control block: AHB-Lite register access, pad
// output routing, input routing, debounce and the edge interrupt.
// Assumes the pad model resolves the wire; debounce shortened to 4 and 2.
`timescale 1ns/100ps

module tb_pfc_pin_ctrl
  import pfc_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin_out, pin_oe_n;
  logic pull_up_en, pull_down_en, supply_domain_select, irq, ext_en, ext_level;
  logic wire_level;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, v;
  pfc_src_t src;
  pfc_req_t req;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int i, k;

  pfc_pin_ctrl #(.LONG_DB_CYCLES(4), .NORMAL_DB_CYCLES(2)) pfc_pin_ctrl_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(wire_level),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .supply_domain_select(supply_domain_select),
    .src(src), .req(req), .irq(irq));

  pfc_pad_model pfc_pad_model_inst (
    .hclk(hclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .ext_en(ext_en), .ext_level(ext_level),
    .wire_level(wire_level));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run needs under a thousand cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string name);
    xfer(1'b0, a, 32'h0);
    check(name, v, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic drive(input logic l, input pfc_src_t s);
    @(posedge hclk);
    ext_level <= l;
    src <= s;
  endtask

  function automatic logic [31:0] ctrl(input logic dir, input logic [1:0] pl, input logic m,
                                       input logic sup, input logic p, input logic od,
                                       input logic en, input logic [3:0] fn);
    return {16'h0, dir, pl, m, sup, p, od, 1'b0, en, 3'h0, fn};
  endfunction

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    src = '0;
    ext_en = 1'b0;
    ext_level = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(CTRL_ADDR, 32'h0000_A400, "ctrl reset");
    check("pads reset", {pin_oe_n, pull_up_en, pull_down_en, hresp}, 4'hA);
    rd(32'h0000_0040, 32'h0, "unmapped");
    for (i = 0; i < 4; i++) begin
      wr(CTRL_ADDR, ctrl(1'b1, i[1:0], 1'b0, i[0], 1'b1, 1'b0, 1'b0, 4'h0));
      settle(2);
      check("pulls", {pull_up_en, pull_down_en}, (i == 1) ? 1 : (i == 2) ? 2 : 0);
      check("supply", supply_domain_select, i[0]);
    end
    wr(OUT_LEVEL_ADDR, 32'h1);
    wr(CTRL_ADDR, ctrl(1'b0, PULL_UP, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, FN_OUT_GP));
    rd(CTRL_ADDR, ctrl(1'b0, PULL_UP, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, FN_OUT_GP), "ctrl rw");
    settle(2);
    check("gp out high", {pin_oe_n, wire_level}, 2'b01);
    wr(CTRL_ADDR, ctrl(1'b0, PULL_UP, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, FN_OUT_GP));
    settle(2);
    check("od release", {pin_oe_n, wire_level}, 2'b11);
    wr(OUT_LEVEL_ADDR, 32'h0);
    settle(2);
    check("od low", {pin_oe_n, wire_level}, 2'b00);
    // Inverted polarity turns a low output level into a high pin
    wr(CTRL_ADDR, ctrl(1'b0, PULL_UP, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, FN_OUT_GP));
    settle(2);
    check("inverted out", {pin_oe_n, wire_level}, 2'b01);
    for (i = 1; i < 16; i++) begin
      k = (i < 5) ? 12 - i : 15 - i;
      wr(CTRL_ADDR, ctrl(1'b0, PULL_NONE, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, i[3:0]));
      drive(1'b0, pfc_src_t'(12'h1 << k));
      settle(2);
      check("src high", {pin_oe_n, wire_level}, {1'b0, i < 5 || i > 7});
      drive(1'b0, pfc_src_t'(~(12'h1 << k)));
      settle(2);
      check("src low", {pin_oe_n, wire_level}, 2'b00);
    end
    wr(CTRL_ADDR, ctrl(1'b0, PULL_NONE, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, FN_OUT_GP));
    settle(2);
    check("disabled", pin_oe_n, 1'b1);
    ext_en <= 1'b1;
    wr(INT_MASK_ADDR, 32'h1);
    for (i = 0; i < 4; i++) begin
      wr(CTRL_ADDR, ctrl(1'b1, PULL_DOWN, i[1], 1'b0, i[0], 1'b0, 1'b1, FN_IN_GP_FAST));
      drive(1'b0, '0);
      settle(6);
      wr(INT_STATUS_ADDR, 32'h1);
      drive(1'b1, '0);
      settle(6);
      rd(IN_LEVEL_ADDR, i[0], "in level");
      rd(INT_STATUS_ADDR, i[1] | i[0], "rise event");
      check("irq rise", irq, i[1] | i[0]);
      wr(INT_STATUS_ADDR, 32'h1);
      settle(2);
      check("irq clear", irq, 1'b0);
      drive(1'b0, '0);
      settle(6);
      rd(INT_STATUS_ADDR, i[1] | !i[0], "fall event");
      wr(INT_STATUS_ADDR, 32'h1);
    end
    wr(INT_MASK_ADDR, 32'h0);
    drive(1'b1, '0);
    settle(6);
    check("masked irq", irq, 1'b0);
    rd(INT_STATUS_ADDR, 32'h1, "masked status");
    wr(INT_MASK_ADDR, 32'h1);
    for (i = 0; i < 2; i++) begin
      wr(CTRL_ADDR, ctrl(1'b1, PULL_DOWN, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, i[3:0]));
      settle(8);
      wr(INT_STATUS_ADDR, 32'h1);
      drive(1'b0, '0);
      drive(1'b0, '0);
      drive(1'b1, '0);
      settle(12);
      rd(INT_STATUS_ADDR, i, "short pulse");
    end
    for (i = 0; i < 16; i++) begin
      k = (i < 4) ? 12 - i : (i < 14) ? 13 - i : 15 - i;
      wr(CTRL_ADDR, ctrl(1'b1, PULL_DOWN, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, i[3:0]));
      drive(1'b1, '0);
      settle(12);
      check("req on", req, (i < 2) ? 0 : 1 << k);
      drive(1'b0, '0);
      settle(12);
      check("req off", req, 0);
    end
    wr(CTRL_ADDR, ctrl(1'b1, PULL_DOWN, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, FN_IN_PWR_ONOFF));
    drive(1'b1, '0);
    settle(12);
    check("req disabled", req, 0);
    final_report();
  end
endmodule
